// ---- core/ump_pkg.sv ----
// Constants for one asynchronous serial channel: pin functions and extras.
// Assumes an APB master on pclk and a 16x oversampled bit clock.
package ump_pkg;
	localparam int          ADDR_W      = 8;
	// Register byte offsets
	localparam logic [7:0]  OFF_MODE    = 8'h00;
	localparam logic [7:0]  OFF_FLOW    = 8'h04;
	localparam logic [7:0]  OFF_CTRL    = 8'h08;
	localparam logic [7:0]  OFF_PORT    = 8'h0c;
	localparam logic [7:0]  OFF_BRG     = 8'h10;
	localparam logic [7:0]  OFF_TXBUF   = 8'h14;
	localparam logic [7:0]  OFF_RXBUF   = 8'h18;
	localparam logic [7:0]  OFF_STAT    = 8'h1c;
	localparam logic [7:0]  OFF_MASK    = 8'h20;
	// Mode register fields
	localparam int          B_ON        = 0;
	localparam int          B_EXTCLK    = 3;
	localparam int          B_ODRAIN    = 5;
	localparam int          B_SLEEP     = 7;
	// Flow register fields
	localparam int          B_RTSSEL    = 2;
	localparam int          B_FLOWOFF   = 4;
	// Control register fields
	localparam int          B_TXEN      = 0;
	localparam int          B_RXEN      = 2;
	localparam int          B_POLREV    = 5;
	localparam int          B_DATINV    = 6;
	// Port register: direction bits, then output levels
	localparam int          B_DIR_IN    = 0;
	localparam int          B_DIR_CLK   = 1;
	localparam int          B_DIR_FLOW  = 2;
	localparam int          B_OUT_IN    = 4;
	localparam int          B_OUT_CLK   = 5;
	localparam int          B_OUT_FLOW  = 6;
	// Status and mask fields, then the receive buffer valid bit
	localparam int          B_EV_TX     = 0;
	localparam int          B_EV_RX     = 1;
	localparam int          B_EV_COLL   = 2;
	localparam int          B_RXVALID   = 8;
	// Reset values and framing
	localparam logic [7:0]  RST_REG     = 8'h00;
	localparam logic [3:0]  OVS_LAST    = 4'hf;
	localparam logic [3:0]  OVS_MID     = 4'h7;
	localparam logic [3:0]  FRAME_LAST  = 4'h9;
endpackage

// ---- core/ump_eng_if.sv ----
// Link between channel control and the serial shift engine.
// Assumes both ends sit on the same pclk domain.
`timescale 1ns/1ps
interface ump_eng_if;
	logic       tick;
	logic       tx_load;
	logic [7:0] tx_data;
	logic       tx_busy;
	logic       tx_line;
	logic       tx_done;
	logic       bit_edge;
	logic       rx_en;
	logic       rx_line;
	logic       rx_done;
	logic [7:0] rx_data;
	modport eng (input tick, tx_load, tx_data, rx_en, rx_line,
		output tx_busy, tx_line, tx_done, bit_edge, rx_done, rx_data);
	modport ctl (output tick, tx_load, tx_data, rx_en, rx_line,
		input tx_busy, tx_line, tx_done, bit_edge, rx_done, rx_data);
endinterface

// ---- core/ump_engine.sv ----
// Serial shift engine: 8 data bits, one start and one stop bit.
// Assumes a 16x tick enable and a synchronised receive line.
`timescale 1ns/1ps
module ump_engine
	import ump_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	ump_eng_if.eng    e
);
	typedef struct packed {
		logic       tx_busy;
		logic [9:0] tx_sh;
		logic [3:0] tx_sub;
		logic [3:0] tx_cnt;
		logic       tx_done;
		logic       rx_busy;
		logic [3:0] rx_sub;
		logic [3:0] rx_cnt;
		logic [8:0] rx_sh;
		logic       rx_done;
	} ump_eng_st_t;

	ump_eng_st_t q;
	ump_eng_st_t d;

	// ************************************************
	// Next state
	// ************************************************
	always_comb
	begin
		d         = q;
		d.tx_done = 1'b0;
		d.rx_done = 1'b0;
		// Start and stop framed here, so inversion upstream spares them
		if (!q.tx_busy && e.tx_load)
		begin
			d.tx_busy = 1'b1;
			d.tx_sh   = {1'b1, e.tx_data, 1'b0};
			d.tx_sub  = 4'h0;
			d.tx_cnt  = 4'h0;
		end
		else if (q.tx_busy && e.tick)
		begin
			d.tx_sub = q.tx_sub + 4'h1;
			if (q.tx_sub == OVS_LAST)
			begin
				d.tx_sh  = {1'b1, q.tx_sh[9:1]};
				d.tx_cnt = q.tx_cnt + 4'h1;
				if (q.tx_cnt == FRAME_LAST)
				begin
					d.tx_busy = 1'b0;
					d.tx_done = 1'b1;
				end
			end
		end
		// Receive: start on low line, sample mid-bit
		if (!q.rx_busy)
		begin
			if (e.rx_en && e.tick && !e.rx_line)
			begin
				d.rx_busy = 1'b1;
				d.rx_sub  = 4'h0;
				d.rx_cnt  = 4'h0;
			end
		end
		else if (e.tick)
		begin
			d.rx_sub = q.rx_sub + 4'h1;
			if (q.rx_sub == OVS_MID)
			begin
				d.rx_cnt = q.rx_cnt + 4'h1;
				// Glitch shorter than half a bit is not a start
				if (q.rx_cnt == 4'h0 && e.rx_line)
					d.rx_busy = 1'b0;
				else if (q.rx_cnt != 4'h0)
					d.rx_sh = {e.rx_line, q.rx_sh[8:1]};
				if (q.rx_cnt == FRAME_LAST)
				begin
					d.rx_busy = 1'b0;
					d.rx_done = 1'b1;
				end
			end
		end
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	// Idle line is high between frames
	assign e.tx_line  = q.tx_busy ? q.tx_sh[0] : 1'b1;
	assign e.tx_busy  = q.tx_busy;
	assign e.tx_done  = q.tx_done;
	assign e.bit_edge = q.tx_busy && e.tick && q.tx_sub == OVS_MID;
	assign e.rx_done  = q.rx_done;
	assign e.rx_data  = q.rx_sh[7:0];

	// ************************************************
	// Checks
	// ************************************************
	property p_stop_idle;
		@(posedge pclk) disable iff (!presetn)
		q.tx_done |-> e.tx_line && !e.tx_busy;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("line not idle high after stop bit");
endmodule

// ---- core/ump_uart_chan.sv ----
// One serial channel in asynchronous mode: APB registers, pin functions,
// sleep filter, data inversion, polarity reversal, collision detect.
// Assumes pins are resolved outside from drive and enable signals.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ump_uart_chan
	import ump_pkg::*;
#(
	parameter int CHANNEL = 0
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	output logic                   serial_out_pin_drv,
	output logic                   serial_out_pin_oe,
	input  wire logic              serial_in_pin,
	output logic                   serial_in_pin_drv,
	output logic                   serial_in_pin_oe,
	input  wire logic              transfer_clock_pin,
	output logic                   transfer_clock_pin_drv,
	output logic                   transfer_clock_pin_oe,
	input  wire logic              flow_control_pin,
	output logic                   flow_control_pin_drv,
	output logic                   flow_control_pin_oe
);
	// ************************************************
	// Elaboration check
	// ************************************************
	if (CHANNEL < 0 || CHANNEL > 2)
		$error("CHANNEL must be 0, 1 or 2");

	localparam logic IS_CH2 = (CHANNEL == 2);

	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  flow;
		logic [7:0]  ctrl;
		logic [7:0]  port;
		logic [7:0]  brg;
		logic [7:0]  div;
		logic [7:0]  txbuf;
		logic        tx_full;
		logic [7:0]  rxbuf;
		logic        rx_valid;
		logic [2:0]  stat;
		logic [2:0]  mask;
		logic [2:0]  sy1;
		logic [2:0]  sy2;
		logic        clk_prev;
		logic        tx_load;
		logic [31:0] rdata;
		logic        err;
	} ump_chan_st_t;

	ump_chan_st_t q;
	ump_chan_st_t d;
	ump_eng_if    eng ();

	// ************************************************
	// Helpers
	// ************************************************
	// Known register offsets; others answer with an error
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = a == OFF_MODE || a == OFF_FLOW || a == OFF_CTRL ||
			a == OFF_PORT || a == OFF_BRG || a == OFF_TXBUF ||
			a == OFF_RXBUF || a == OFF_STAT || a == OFF_MASK;
	endfunction

	// Channel 2 only: data bits flipped at the buffer boundary
	function automatic logic [7:0] inv8(input logic [7:0] v,
		input logic en);
		inv8 = en ? ~v : v;
	endfunction

	logic       wr;
	logic       rd_acc;
	logic       setup;
	logic       ext_act;
	logic       clk_rise;
	logic       src;
	logic       tick;
	logic       pol;
	logic       inv;
	logic       sleep;
	logic       cts_ok;
	logic       rts_mode;
	logic       out_lvl;
	logic       coll;
	logic       keep_rx;
	logic [2:0] ev;

	// ************************************************
	// Decode and pin functions
	// ************************************************
	always_comb
	begin
		wr       = psel && penable && pwrite;
		rd_acc   = psel && penable && !pwrite;
		setup    = psel && !penable;
		// External clock needs select set and pin input; never channel 2
		ext_act  = !IS_CH2 && q.mode[B_EXTCLK] && !q.port[B_DIR_CLK];
		clk_rise = q.sy2[1] && !q.clk_prev;
		src      = ext_act ? clk_rise : 1'b1;
		tick     = src && q.div == 8'h00;
		pol      = IS_CH2 && q.ctrl[B_POLREV];
		inv      = IS_CH2 && q.ctrl[B_DATINV];
		sleep    = !IS_CH2 && q.mode[B_SLEEP];
		// CTS is active low and only counts while the pin is input
		cts_ok   = q.flow[B_FLOWOFF] || q.flow[B_RTSSEL] ||
			q.port[B_DIR_FLOW] || !q.sy2[2];
		rts_mode = !q.flow[B_FLOWOFF] && q.flow[B_RTSSEL];
		out_lvl  = eng.tx_line ^ pol;
		// Compare the driven level with the sampled pin level
		coll     = IS_CH2 && eng.bit_edge && out_lvl != q.sy2[0];
		keep_rx  = !(sleep && !eng.rx_data[7]);
		ev       = {coll, eng.rx_done && keep_rx, q.tx_load};
	end

	// ************************************************
	// Next state
	// ************************************************
	always_comb
	begin
		d         = q;
		// Two flops on every pin input before use
		d.sy1     = {flow_control_pin, transfer_clock_pin, serial_in_pin};
		d.sy2     = q.sy1;
		d.clk_prev = q.sy2[1];
		// Bit-rate divider: tick every n+1 source pulses
		if (tick)
			d.div = q.brg;
		else if (src)
			d.div = q.div - 8'h01;
		// Buffer handed to the engine once enabled and CTS permits
		d.tx_load = q.mode[B_ON] && q.ctrl[B_TXEN] && q.tx_full &&
			cts_ok && !eng.tx_busy && !q.tx_load;
		if (q.tx_load)
			d.tx_full = 1'b0;
		// Read of receive buffer takes the valid flag away
		if (rd_acc && paddr == OFF_RXBUF)
			d.rx_valid = 1'b0;
		if (wr)
		begin
			unique case (paddr)
				OFF_MODE:  d.mode = pwdata[7:0];
				OFF_FLOW:  d.flow = pwdata[7:0];
				OFF_CTRL:  d.ctrl = pwdata[7:0];
				OFF_PORT:  d.port = pwdata[7:0];
				OFF_BRG:   d.brg  = pwdata[7:0];
				OFF_MASK:  d.mask = pwdata[2:0];
				OFF_STAT:  d.stat = q.stat & ~pwdata[2:0];
				OFF_TXBUF:
				begin
					d.txbuf   = inv8(pwdata[7:0], inv);
					d.tx_full = 1'b1;
				end
				default: ;
			endcase
		end
		// Sleep filter drops characters with a clear MSB
		if (eng.rx_done && keep_rx)
		begin
			d.rxbuf    = eng.rx_data;
			d.rx_valid = 1'b1;
		end
		// Sticky events; a set in the clearing cycle wins
		d.stat = d.stat | ev;
		// Read data captured in setup, so prdata comes from a flop
		if (setup)
		begin
			d.err   = !mapped(paddr);
			d.rdata = 32'h0000_0000;
			unique case (paddr)
				OFF_MODE:  d.rdata[7:0] = q.mode;
				OFF_FLOW:  d.rdata[7:0] = q.flow;
				OFF_CTRL:  d.rdata[7:0] = q.ctrl;
				OFF_PORT:  d.rdata[10:0] = {q.sy2, q.port};
				OFF_BRG:   d.rdata[7:0] = q.brg;
				OFF_TXBUF: d.rdata[8] = q.tx_full;
				OFF_RXBUF: d.rdata[8:0] =
					{q.rx_valid, inv8(q.rxbuf, inv)};
				OFF_STAT:  d.rdata[2:0] = q.stat;
				OFF_MASK:  d.rdata[2:0] = q.mask;
				default: ;
			endcase
		end
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q      <= '0;
			q.mode <= RST_REG;
			q.flow <= RST_REG;
			q.ctrl <= RST_REG;
			q.port <= RST_REG;
			q.brg  <= RST_REG;
		end
		else
			q <= d;
	end

	// ************************************************
	// Engine
	// ************************************************
	assign eng.tick    = tick;
	assign eng.tx_load = q.tx_load;
	assign eng.tx_data = q.txbuf;
	// Receive only while the input pin is not driven as a port
	assign eng.rx_en   = q.mode[B_ON] && q.ctrl[B_RXEN] &&
		!q.port[B_DIR_IN];
	assign eng.rx_line = q.sy2[0] ^ pol;

	ump_engine u_eng (
		.pclk    (pclk),
		.presetn (presetn),
		.e       (eng)
	);

	// ************************************************
	// Bus and pin outputs
	// ************************************************
	assign prdata  = q.rdata;
	assign pslverr = q.err && psel && penable;
	assign pready  = penable;
	assign irq     = |(q.stat & q.mask);

	// High while idle unless polarity reversed; open drain only pulls low, so a high idle floats
	assign serial_out_pin_oe  = q.mode[B_ON] &&
		(!q.mode[B_ODRAIN] || !out_lvl);
	assign serial_out_pin_drv = out_lvl && !q.mode[B_ODRAIN];
	assign serial_in_pin_oe   = q.port[B_DIR_IN];
	assign serial_in_pin_drv  = q.port[B_OUT_IN];
	// Clock pin is never driven as a transfer clock in this mode
	assign transfer_clock_pin_oe  = q.port[B_DIR_CLK];
	assign transfer_clock_pin_drv = q.port[B_OUT_CLK];
	// RTS low means ready to take a character
	assign flow_control_pin_oe  = rts_mode || q.port[B_DIR_FLOW];
	assign flow_control_pin_drv = rts_mode ?
		!(q.ctrl[B_RXEN] && !q.rx_valid) : q.port[B_OUT_FLOW];

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_idle_high;
		q.mode[B_ON] && !q.mode[B_ODRAIN] && !pol && !eng.tx_busy
			|-> serial_out_pin_oe && serial_out_pin_drv;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("serial output not driven high while idle");

	property p_od_float;
		q.mode[B_ON] && q.mode[B_ODRAIN] && !pol && !eng.tx_busy
			|-> !serial_out_pin_oe;
	endproperty
	a_od_float: assert property (p_od_float)
		else $error("open-drain output not floating while idle");

	property p_no_ext_ch2;
		IS_CH2 |-> !ext_act && src;
	endproperty
	a_no_ext_ch2: assert property (p_no_ext_ch2)
		else $error("external clock active on channel 2");

	property p_cts_block;
		!q.flow[B_FLOWOFF] && !q.flow[B_RTSSEL] && !q.port[B_DIR_FLOW]
			&& q.sy2[2] |=> !q.tx_load;
	endproperty
	a_cts_block: assert property (p_cts_block)
		else $error("transmit started while CTS high");

	property p_rts_out;
		rts_mode && !q.rx_valid && q.ctrl[B_RXEN]
			|-> flow_control_pin_oe && !flow_control_pin_drv;
	endproperty
	a_rts_out: assert property (p_rts_out)
		else $error("RTS not asserted while ready");

	property p_flow_gpio;
		q.flow[B_FLOWOFF] |-> flow_control_pin_oe == q.port[B_DIR_FLOW]
			&& flow_control_pin_drv == q.port[B_OUT_FLOW];
	endproperty
	a_flow_gpio: assert property (p_flow_gpio)
		else $error("flow pin not plain port with flow off");

	property p_sleep_drop;
		eng.rx_done && sleep && !eng.rx_data[7] && !rd_acc
			|=> $stable(q.rx_valid) && $stable(q.rxbuf);
	endproperty
	a_sleep_drop: assert property (p_sleep_drop)
		else $error("sleep mode kept a character with MSB zero");

	property p_tx_inv;
		wr && paddr == OFF_TXBUF |=> q.txbuf == inv8($past(pwdata[7:0]),
			$past(inv));
	endproperty
	a_tx_inv: assert property (p_tx_inv)
		else $error("transmit buffer inversion wrong");

	property p_coll_set;
		coll |=> q.stat[B_EV_COLL];
	endproperty
	a_coll_set: assert property (p_coll_set)
		else $error("collision not flagged");

	property p_coll_hold;
		q.stat[B_EV_COLL] && !(wr && paddr == OFF_STAT &&
			pwdata[B_EV_COLL]) |=> q.stat[B_EV_COLL];
	endproperty
	a_coll_hold: assert property (p_coll_hold)
		else $error("collision flag dropped without clear");
endmodule

// ---- testbench/ump_peer.sv ----
// Far-end serial device: 8N1 frames, LSB first, 16 pclk per bit.
// Assumes the channel runs its bit clock from pclk with a divider of one.
`timescale 1ns/1ps
module ump_peer
(
	input  wire logic pclk,
	input  wire logic tx_line,
	input  wire logic inv,
	input  wire logic echo,
	output logic      rx_line
);
	// ****************************************
	// Line drive and frame tasks
	// ****************************************
	logic own_q;

	// Idle level high; echo mirrors the channel so a clean bus sees no clash
	initial own_q = 1'b1;
	assign rx_line = echo ? tx_line : own_q ^ inv;

	// Whole frame: start low, eight data bits, stop high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge pclk);
		for (int i = 0; i < 10; i++)
		begin
			own_q <= f[i];
			repeat (16) @(posedge pclk);
		end
	endtask

	// Bad start or stop makes the byte unknown, so any compare fails
	task automatic recv(output logic [7:0] b);
		int n;
		b = 'x;
		n = 0;
		while ((tx_line ^ inv) !== 1'b0 && n < 4000)
		begin
			@(posedge pclk);
			n++;
		end
		repeat (8) @(posedge pclk);
		if ((tx_line ^ inv) !== 1'b0)
			return;
		for (int i = 0; i < 8; i++)
		begin
			repeat (16) @(posedge pclk);
			b[i] = tx_line ^ inv;
		end
		repeat (16) @(posedge pclk);
		if ((tx_line ^ inv) !== 1'b1)
			b = 'x;
	endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for channels 0 and 2 of the serial block over APB.
// Assumes pull-ups on the serial output lines and a peer on each input.
`timescale 1ns/1ps
module tb
	import ump_pkg::*;
;
	// ****************************************
	// Signals, channels and peers
	// ****************************************
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [1:0]  psel = 2'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0]  inv = 2'h0;
	logic [1:0]  echo = 2'h0;
	logic [1:0]  cts_n = 2'h0;
	logic        ext_clk = 1'b0;
	int          num_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	wire  [31:0] prdata [2];
	wire  [7:0]  pv [2];
	wire  [1:0]  pready, pslverr, irq, so, si, ck, fl, pr_line;
	wire  [1:0]  so_d, so_e, si_d, si_e, ck_d, ck_e, fl_d, fl_e;

	always #2 pclk = ~pclk;

	// Index 0 is channel 0, index 1 is channel 2
	for (genvar g = 0; g < 2; g++)
	begin : g_ch
		ump_uart_chan #(.CHANNEL(2 * g)) i_ump_uart_chan (
			.pclk(pclk), .presetn(presetn), .paddr(paddr),
			.psel(psel[g]), .penable(penable), .pwrite(pwrite),
			.pwdata(pwdata), .prdata(prdata[g]), .pready(pready[g]),
			.pslverr(pslverr[g]), .irq(irq[g]),
			.serial_out_pin_drv(so_d[g]), .serial_out_pin_oe(so_e[g]),
			.serial_in_pin(si[g]), .serial_in_pin_drv(si_d[g]),
			.serial_in_pin_oe(si_e[g]), .transfer_clock_pin(ck[g]),
			.transfer_clock_pin_drv(ck_d[g]),
			.transfer_clock_pin_oe(ck_e[g]), .flow_control_pin(fl[g]),
			.flow_control_pin_drv(fl_d[g]), .flow_control_pin_oe(fl_e[g]));
		ump_peer i_ump_peer (.pclk(pclk), .tx_line(so[g]), .inv(inv[g]),
			.echo(echo[g]), .rx_line(pr_line[g]));
		// Pin levels: pull-up on output, otherwise whoever drives wins
		assign so[g] = so_e[g] ? so_d[g] : 1'b1;
		assign si[g] = si_e[g] ? si_d[g] : pr_line[g];
		assign ck[g] = ck_e[g] ? ck_d[g] : ext_clk;
		assign fl[g] = fl_e[g] ? fl_d[g] : cts_n[g];
		assign pv[g] = {so_e[g], so_d[g], si_e[g], si_d[g],
			ck_e[g], ck_d[g], fl_e[g], fl_d[g]};
	end

	// ****************************************
	// Bus, compare and closing tasks
	// ****************************************
	task automatic apb(input int ch, input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel[ch] <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count assumed; the hang guard ends a stuck access
		do
			@(posedge pclk);
		while (pready[ch] !== 1'b1);
		q = prdata[ch];
		e = pslverr[ch];
		psel[ch] <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got,
		logic [31:0] m);
		compares++;
		if ((got & m) !== (exp & m))
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp & m, got & m);
		end
	endtask

	task automatic wr(int ch, logic [7:0] a, logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(ch, 1'b1, a, d, q, e);
	endtask

	task automatic rdc(int ch, logic [7:0] a, logic [31:0] x,
		logic [31:0] m, string nm);
		logic [31:0] q;
		logic        e;
		apb(ch, 1'b0, a, 32'h0, q, e);
		chk(nm, x, q, m);
	endtask

	// Let the access edge land before looking at the pins
	task automatic pins(int ch, logic [7:0] x, logic [7:0] m);
		@(negedge pclk);
		chk("pins", {24'h0, x}, {24'h0, pv[ch]}, {24'h0, m});
	endtask

	task automatic done(string s);
		$display("test %s finished", s);
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard well above the dozen frames the run needs
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		logic [31:0] q;
		logic        e;
		logic [7:0]  b;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(0, OFF_MODE, 32'h0, 32'hffffffff, "mode reset");
		rdc(0, OFF_STAT, 32'h0, 32'hffffffff, "stat reset");
		apb(0, 1'b0, 8'h24, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e}, 32'h1);
		chk("unmapped data", 32'h0, q, 32'hffffffff);
		// Mode off: level still high but the output is not enabled
		pins(0, 8'h40, 8'hc0);
		wr(0, OFF_BRG, 32'h5a);
		rdc(0, OFF_BRG, 32'h5a, 32'hff, "brg");
		wr(0, OFF_BRG, 32'h0);
		done("registers");
		wr(0, OFF_MODE, 32'h21);
		pins(0, 8'h00, 8'hc0);
		chk("od line", 32'h1, {31'h0, so[0]}, 32'h1);
		wr(0, OFF_MODE, 32'h01);
		pins(0, 8'hc0, 8'hc0);
		done("idle line");
		wr(0, OFF_FLOW, 32'h10);
		wr(0, OFF_PORT, 32'h77);
		pins(0, 8'hff, 8'hff);
		wr(0, OFF_MODE, 32'h09);
		wr(0, OFF_PORT, 32'h75);
		pins(0, 8'h20, 8'h28);
		wr(0, OFF_MODE, 32'h01);
		wr(0, OFF_CTRL, 32'h04);
		wr(0, OFF_FLOW, 32'h04);
		wr(0, OFF_PORT, 32'h00);
		pins(0, 8'h02, 8'h2b);
		wr(0, OFF_FLOW, 32'h00);
		pins(0, 8'h00, 8'h02);
		done("pin functions");
		cts_n[0] <= 1'b1;
		wr(0, OFF_MASK, 32'h01);
		wr(0, OFF_CTRL, 32'h05);
		wr(0, OFF_TXBUF, 32'ha5);
		repeat (40) @(posedge pclk);
		chk("cts hold", 32'h1, {31'h0, so[0]}, 32'h1);
		rdc(0, OFF_TXBUF, 32'h100, 32'h100, "tx held");
		cts_n[0] <= 1'b0;
		g_ch[0].i_ump_peer.recv(b);
		chk("tx byte", 32'ha5, {24'h0, b}, 32'hff);
		chk("irq set", 32'h1, {31'h0, irq[0]}, 32'h1);
		rdc(0, OFF_STAT, 32'h1, 32'h1, "stat tx");
		wr(0, OFF_STAT, 32'h1);
		rdc(0, OFF_STAT, 32'h0, 32'h1, "stat clr");
		chk("irq clr", 32'h0, {31'h0, irq[0]}, 32'h1);
		repeat (16) @(posedge pclk);
		chk("line after", 32'h1, {31'h0, so[0]}, 32'h1);
		done("transmit");
		g_ch[0].i_ump_peer.send(8'h3c);
		repeat (20) @(posedge pclk);
		rdc(0, OFF_RXBUF, 32'h13c, 32'h1ff, "rx byte");
		wr(0, OFF_MODE, 32'h81);
		g_ch[0].i_ump_peer.send(8'h3c);
		repeat (20) @(posedge pclk);
		rdc(0, OFF_RXBUF, 32'h0, 32'h100, "sleep drop");
		g_ch[0].i_ump_peer.send(8'hc3);
		repeat (20) @(posedge pclk);
		rdc(0, OFF_RXBUF, 32'h1c3, 32'h1ff, "sleep keep");
		done("receive and sleep");
		// External clock held still: the start bit must not advance
		wr(0, OFF_MODE, 32'h09);
		wr(0, OFF_TXBUF, 32'h96);
		repeat (40) @(posedge pclk);
		chk("ext stall", 32'h0, {31'h0, so[0]}, 32'h1);
		wr(0, OFF_MODE, 32'h01);
		g_ch[0].i_ump_peer.recv(b);
		chk("ext tx", 32'h96, {24'h0, b}, 32'hff);
		done("external clock");
		wr(1, OFF_MODE, 32'h01);
		wr(1, OFF_CTRL, 32'h45);
		wr(1, OFF_TXBUF, 32'h0f);
		g_ch[1].i_ump_peer.recv(b);
		chk("inv tx", 32'hf0, {24'h0, b}, 32'hff);
		g_ch[1].i_ump_peer.send(8'h55);
		repeat (20) @(posedge pclk);
		rdc(1, OFF_RXBUF, 32'h1aa, 32'h1ff, "inv rx");
		done("data invert");
		wr(1, OFF_CTRL, 32'h25);
		inv[1] <= 1'b1;
		repeat (200) @(posedge pclk);
		chk("rev idle", 32'h0, {31'h0, so[1]}, 32'h1);
		wr(1, OFF_TXBUF, 32'h5a);
		g_ch[1].i_ump_peer.recv(b);
		chk("rev tx", 32'h5a, {24'h0, b}, 32'hff);
		g_ch[1].i_ump_peer.send(8'h3c);
		repeat (20) @(posedge pclk);
		rdc(1, OFF_RXBUF, 32'h13c, 32'h1ff, "rev rx");
		wr(1, OFF_CTRL, 32'h05);
		inv[1] <= 1'b0;
		repeat (200) @(posedge pclk);
		done("polarity");
		echo[1] <= 1'b1;
		wr(1, OFF_STAT, 32'h7);
		wr(1, OFF_TXBUF, 32'h00);
		g_ch[1].i_ump_peer.recv(b);
		rdc(1, OFF_STAT, 32'h0, 32'h4, "no clash");
		echo[1] <= 1'b0;
		wr(1, OFF_TXBUF, 32'h00);
		g_ch[1].i_ump_peer.recv(b);
		rdc(1, OFF_STAT, 32'h4, 32'h4, "clash");
		wr(1, OFF_MASK, 32'h4);
		@(negedge pclk);
		chk("clash irq", 32'h1, {31'h0, irq[1]}, 32'h1);
		rdc(1, OFF_STAT, 32'h4, 32'h4, "clash held");
		wr(1, OFF_STAT, 32'h4);
		rdc(1, OFF_STAT, 32'h0, 32'h4, "clash clr");
		chk("irq off", 32'h0, {31'h0, irq[1]}, 32'h1);
		done("collision");
		stop_test();
	end
endmodule
